// >>> core/rca_pkg.sv
// Purpose: shared constants, register map and calendar helpers for the calendar clock.
// Assumes: byte-wide registers reached over the two-wire serial bus only.
// Notes: register map, bit positions and calendar limits kept here; the top module imports the whole package.
// Summary of operation
// - alarm runs only when enabled; mode selectable
// - nonzero frequency select disables alarm function
// - single mode match pulls pin low, sets flag
// - pulsed mode alarms on every enabled match
// - pulsed mode holds pin low 250 ms
// - flag cleared by write or auto-clear
// - backup pin disable silences pin on battery
// - four-bit select picks 15 output frequencies
// - two user bytes kept; bus off on battery
// - slave byte 1101111x, registers 00h to 13h
// - location 09h ignored on write and read
// - single-byte and page writes at any address
// - four sections decoded, nothing above 13h
// - clock writes only while write enable set
// - multi-byte access wraps inside one section
// - clock or alarm read copies time to buffer
// - pointer ends at last read address plus one
// - other sections writable without write enable
// - time kept in BCD with documented ranges
// - weekday counts 0 to 6 and wraps
// - 24-hour bit selects format; PM indicator
// - February 29 when year divisible by 4
// - frequency code table 32768 Hz to 1/32 Hz
// - single mode pin low until flag cleared
// - auto-clear after status read and stop
// - clock write stop starts count, aligns tick
package rca_pkg;
    localparam logic [6:0] I2C_DEV_ADDR = 7'h6f;

    localparam int SYS_CLK_HZ      = 125000000;
    localparam int ALARM_PULSE_MS  = 250;
    localparam int ALARM_PULSE_CYC = (SYS_CLK_HZ / 1000) * ALARM_PULSE_MS;
    localparam int PRESC_W         = 20;
    localparam logic [14:0] PRESC_SEC_WRAP = 15'h7fff;

    // prescaler bit that toggles at each selectable rate; code 1 uses the crystal itself
    localparam int FREQ_TAP [16] = '{0, 0, 2, 4, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19};

    localparam logic [7:0] A_SEC   = 8'h00;
    localparam logic [7:0] A_WDAY  = 8'h06;
    localparam logic [7:0] A_SR    = 8'h07;
    localparam logic [7:0] A_CFG   = 8'h08;
    localparam logic [7:0] A_UNUSE = 8'h09;
    localparam logic [7:0] A_ATRIM = 8'h0a;
    localparam logic [7:0] A_DTRIM = 8'h0b;
    localparam logic [7:0] A_ALSEC = 8'h0c;
    localparam logic [7:0] A_ALWD  = 8'h11;
    localparam logic [7:0] A_USER_BYTE_ONE  = 8'h12;
    localparam logic [7:0] A_USER_BYTE_TWO  = 8'h13;

    localparam int T_SEC  = 0;
    localparam int T_MIN  = 1;
    localparam int T_HOUR = 2;
    localparam int T_DATE = 3;
    localparam int T_MON  = 4;
    localparam int T_YEAR = 5;
    localparam int T_WDAY = 6;

    localparam int SR_AUTO_CLEAR_ENABLE  = 7;
    localparam int SR_XTOSC = 6;
    localparam int SR_CLOCK_WRITE_ENABLE  = 4;
    localparam int SR_ALM   = 2;
    localparam int SR_BAT   = 1;
    localparam int SR_RTCF  = 0;
    localparam int CF_IM    = 7;
    localparam int CF_ALARM_ENABLE  = 6;
    localparam int CF_FOBAT = 4;
    localparam int HR_MIL   = 7;
    localparam int HR_PM    = 5;
    localparam int AL_EN    = 7;

    localparam logic [7:0] SR_RESET  = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;

    localparam logic [7:0] TIME_MASK [7] = '{8'h7f, 8'h7f, 8'hbf, 8'h3f, 8'h1f, 8'hff, 8'h07};
    localparam logic [7:0] ALRM_MASK [6] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h9f, 8'h87};
    localparam logic [7:0] DTRIM_MASK    = 8'h07;

    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_11 = 8'h11;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [2:0] WDAY_MAX = 3'h6;

    // last day of the month in BCD; leap test works on the two BCD year digits
    function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02:                      last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
    endfunction

    // pointer advance that stays inside the current section
    function automatic logic [7:0] next_ptr(input logic [7:0] a);
        case (a)
            A_WDAY:  next_ptr = A_SEC;
            A_DTRIM: next_ptr = A_SR;
            A_ALWD:  next_ptr = A_ALSEC;
            A_USER_BYTE_TWO:  next_ptr = A_USER_BYTE_ONE;
            default: next_ptr = a + 8'h01;
        endcase
    endfunction
endpackage

// >>> core/rca_sync.sv
// Purpose: three-stage synchroniser for a pin input.
// Assumes: din is asynchronous to clk_sys.
// Notes: output moves only when the second and third stages agree.
`timescale 1ns/100ps
module rca_sync
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic s1Q, s2Q, s3Q, outQ;
    logic outD;

    always_comb
    begin
        outD = (s2Q == s3Q) ? s3Q : outQ;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1Q  <= 1'b1;
            s2Q  <= 1'b1;
            s3Q  <= 1'b1;
            outQ <= 1'b1;
        end
        else
        begin
            s1Q  <= din;
            s2Q  <= s1Q;
            s3Q  <= s2Q;
            outQ <= outD;
        end
    end

    assign dout = outQ;
endmodule

// >>> core/rca_bcd_inc.sv
// Purpose: BCD increment with wrap from a top value back to a bottom value.
// Assumes: val is legal BCD.
// Notes: wrap flags the carry into the next field.
`timescale 1ns/100ps
module rca_bcd_inc
(
    input  wire logic [7:0] val,
    input  wire logic [7:0] maxVal,
    input  wire logic [7:0] minVal,
    output logic      [7:0] nxt,
    output logic            wrap
);
    always_comb
    begin
        wrap = (val == maxVal);
        if (wrap)
            nxt = minVal;
        else if (val[3:0] == 4'h9)
            nxt = {val[7:4] + 4'h1, 4'h0};
        else
            nxt = val + 8'h01;
    end
endmodule

// >>> core/rca_rtc_top.sv
// Purpose: calendar clock with alarm, frequency output and user bytes behind a serial slave.
// Assumes: pins arrive asynchronously; crystal, bus clock and battery flag pass synchronisers.
// Notes: SDA and the alarm pin are open drain; only the enables ever move.
`timescale 1ns/100ps
module rca_rtc_top
    import rca_pkg::*;
#(
    parameter int PULSE_CYCLES = ALARM_PULSE_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic sclPin,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    input  wire logic xtalIn,
    input  wire logic onBatteryPin,
    output logic      alarmFreqOut,
    output logic      alarmFreqOe
);
    localparam int PW = $clog2(PULSE_CYCLES + 1);

    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_RD} rca_i2c_e;

    logic sclS, sdaS, xtalS, batS;

    rca_sync uSclSync  (.clk_sys(clk_sys), .rstn(rstn), .din(sclPin),       .dout(sclS));
    rca_sync uSdaSync  (.clk_sys(clk_sys), .rstn(rstn), .din(sdaIn),        .dout(sdaS));
    rca_sync uXtalSync (.clk_sys(clk_sys), .rstn(rstn), .din(xtalIn),       .dout(xtalS));
    rca_sync uBatSync  (.clk_sys(clk_sys), .rstn(rstn), .din(onBatteryPin), .dout(batS));

    // bus edge detection
    logic sclPrevQ, sdaPrevQ;
    logic sclRise, sclFall, startEv, stopEv;

    assign sclRise = sclS & ~sclPrevQ;
    assign sclFall = ~sclS & sclPrevQ;
    assign startEv = sclS & sclPrevQ & sdaPrevQ & ~sdaS;
    assign stopEv  = sclS & sclPrevQ & ~sdaPrevQ & sdaS;

    // register state
    logic [7:0] timeQ [7];
    logic [7:0] timeD [7];
    logic [7:0] snapQ [7];
    logic [7:0] snapD [7];
    logic [7:0] alrmQ [6];
    logic [7:0] alrmD [6];
    logic [7:0] usrQ  [2];
    logic [7:0] usrD  [2];
    logic [7:0] cfgQ, cfgD, atrimQ, atrimD, dtrimQ, dtrimD;
    logic       arstQ, arstD, xtoscQ, xtoscD, wrtcQ, wrtcD;
    logic       almQ, almD, batQ, batD, rtcfQ, rtcfD;
    logic       runQ, runD, clkWrQ, clkWrD, srRdQ, srRdD;
    logic [1:0] srMaskQ, srMaskD;
    logic       batPrevQ;

    // serial slave state
    rca_i2c_e   stQ, stD;
    logic [3:0] bitQ, bitD;
    logic [7:0] shQ, shD, txQ, txD, ptrQ, ptrD;
    logic       ackQ, ackD, nackQ, nackD;
    logic       wrStb, rdLoad, snapTake;
    logic [7:0] rdData;

    // timebase and alarm state
    logic               xtalPrevQ, tickQ, tickD, tickDlyQ;
    logic [PRESC_W-1:0] prescQ, prescD;
    logic [PW-1:0]      pulseQ, pulseD;
    logic               pinLowQ, pinLowD;

    logic [7:0] rdStatus;
    assign rdStatus = {arstQ, xtoscQ, 1'b0, wrtcQ, 1'b0, almQ, batQ, rtcfQ};

    always_comb
    begin
        rdData = REG_RESET;
        if (ptrQ <= A_WDAY)
            rdData = snapQ[ptrQ[2:0]];
        else if (ptrQ >= A_ALSEC && ptrQ <= A_ALWD)
            rdData = alrmQ[3'(ptrQ - A_ALSEC)];
        else
        begin
            unique case (ptrQ)
                A_SR:    rdData = rdStatus;
                A_CFG:   rdData = cfgQ;
                A_ATRIM: rdData = atrimQ;
                A_DTRIM: rdData = dtrimQ;
                A_USER_BYTE_ONE:  rdData = usrQ[0];
                A_USER_BYTE_TWO:  rdData = usrQ[1];
                default: rdData = REG_RESET;
            endcase
        end
    end

    // serial slave: bits shift on SCL rise, SDA moves after SCL fall
    always_comb
    begin
        stD      = stQ;
        bitD     = bitQ;
        shD      = shQ;
        txD      = txQ;
        ptrD     = ptrQ;
        ackD     = ackQ;
        nackD    = nackQ;
        wrStb    = 1'b0;
        rdLoad   = 1'b0;
        snapTake = 1'b0;
        if (batS || startEv || stopEv)
        begin
            stD   = (batS || stopEv) ? I_IDLE : I_ADDR;
            bitD  = 4'h0;
            ackD  = 1'b0;
            nackD = 1'b0;
        end
        else if (stQ != I_IDLE)
        begin
            if (sclRise)
            begin
                if (bitQ < 4'h8)
                begin
                    bitD = 4'(bitQ + 4'h1);
                    if (stQ != I_RD)
                        shD = {shQ[6:0], sdaS};
                end
                else if (bitQ == 4'h8)
                begin
                    bitD  = 4'h9;
                    nackD = sdaS;
                end
            end
            else if (sclFall)
            begin
                if (bitQ == 4'h8)
                begin
                    unique case (stQ)
                        I_ADDR:
                        begin
                            if (shQ[7:1] == I2C_DEV_ADDR)
                            begin
                                ackD = 1'b1;
                                if (shQ[0])
                                begin
                                    stD = I_RD;
                                    snapTake = (ptrQ <= A_WDAY) || (ptrQ >= A_ALSEC && ptrQ <= A_ALWD);
                                end
                                else
                                    stD = I_PTR;
                            end
                            else
                                stD = I_IDLE;
                        end
                        I_PTR:
                        begin
                            ptrD = shQ;
                            ackD = 1'b1;
                            stD  = I_WR;
                        end
                        I_WR:
                        begin
                            wrStb = 1'b1;
                            ptrD  = next_ptr(ptrQ);
                            ackD  = 1'b1;
                        end
                        I_RD, I_IDLE:
                        begin
                            txD = {txQ[6:0], 1'b1};
                        end
                    endcase
                end
                else if (bitQ == 4'h9)
                begin
                    bitD = 4'h0;
                    ackD = 1'b0;
                    if (stQ == I_RD)
                    begin
                        if (nackQ)
                            stD = I_IDLE;
                        else
                        begin
                            rdLoad = 1'b1;
                            txD    = rdData;
                            ptrD   = next_ptr(ptrQ);
                        end
                    end
                end
                else if (stQ == I_RD && bitQ != 4'h0)
                    txD = {txQ[6:0], 1'b1};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            stQ      <= I_IDLE;
            bitQ     <= 4'h0;
            shQ      <= 8'h00;
            txQ      <= 8'h00;
            ptrQ     <= 8'h00;
            ackQ     <= 1'b0;
            nackQ    <= 1'b0;
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end
        else
        begin
            stQ      <= stD;
            bitQ     <= bitD;
            shQ      <= shD;
            txQ      <= txD;
            ptrQ     <= ptrD;
            ackQ     <= ackD;
            nackQ    <= nackD;
            sclPrevQ <= sclS;
            sdaPrevQ <= sdaS;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = ackQ | ((stQ == I_RD) && (bitQ <= 4'h8) && !txQ[7]);

    // calendar increment chain
    logic [7:0] secN, minN, hourN, dateN, monN, yearN, hourVal;
    logic       secW, minW, hourW, dateW, monW, yearW;
    logic       twenty_four_hour, pm, dayCarry;

    assign twenty_four_hour     = timeQ[T_HOUR][HR_MIL];
    assign pm      = timeQ[T_HOUR][HR_PM];
    assign hourVal = twenty_four_hour ? {2'b00, timeQ[T_HOUR][5:0]} : {3'b000, timeQ[T_HOUR][4:0]};

    rca_bcd_inc uSecInc  (.val(timeQ[T_SEC]), .maxVal(BCD_59), .minVal(BCD_00), .nxt(secN), .wrap(secW));
    rca_bcd_inc uMinInc  (.val(timeQ[T_MIN]), .maxVal(BCD_59), .minVal(BCD_00), .nxt(minN), .wrap(minW));
    rca_bcd_inc uHourInc (.val(hourVal), .maxVal(twenty_four_hour ? BCD_23 : BCD_12), .minVal(twenty_four_hour ? BCD_00 : BCD_01),
                          .nxt(hourN), .wrap(hourW));
    rca_bcd_inc uDateInc (.val(timeQ[T_DATE]), .maxVal(last_day(timeQ[T_MON], timeQ[T_YEAR])), .minVal(BCD_01),
                          .nxt(dateN), .wrap(dateW));
    rca_bcd_inc uMonInc  (.val(timeQ[T_MON]), .maxVal(BCD_12), .minVal(BCD_01), .nxt(monN), .wrap(monW));
    rca_bcd_inc uYearInc (.val(timeQ[T_YEAR]), .maxVal(BCD_99), .minVal(BCD_00), .nxt(yearN), .wrap(yearW));

    assign dayCarry = twenty_four_hour ? hourW : (hourVal == BCD_11 && pm);

    // alarm compare
    logic [7:0] almField [6];
    logic       almMatch, anyEn, alarmOn, almEvent;

    assign almField = '{timeQ[T_SEC], timeQ[T_MIN], timeQ[T_HOUR], timeQ[T_DATE], timeQ[T_MON], timeQ[T_WDAY]};

    always_comb
    begin
        almMatch = 1'b1;
        anyEn    = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            if (alrmQ[i][AL_EN])
            begin
                anyEn = 1'b1;
                if (alrmQ[i][6:0] != (almField[i][6:0] & ALRM_MASK[i][6:0]))
                    almMatch = 1'b0;
            end
        end
    end

    assign alarmOn  = cfgQ[CF_ALARM_ENABLE] && (cfgQ[3:0] == 4'h0);
    assign almEvent = alarmOn && tickDlyQ && anyEn && almMatch;

    // register file, counting and flags
    always_comb
    begin
        timeD   = timeQ;
        snapD   = snapQ;
        alrmD   = alrmQ;
        usrD    = usrQ;
        cfgD    = cfgQ;
        atrimD  = atrimQ;
        dtrimD  = dtrimQ;
        arstD   = arstQ;
        xtoscD  = xtoscQ;
        wrtcD   = wrtcQ;
        almD    = almQ;
        batD    = batQ;
        rtcfD   = rtcfQ;
        runD    = runQ;
        clkWrD  = clkWrQ;
        srRdD   = srRdQ;
        srMaskD = srMaskQ;
        if (tickQ && runQ)
        begin
            timeD[T_SEC] = secN;
            if (secW)
                timeD[T_MIN] = minN;
            if (secW && minW)
            begin
                timeD[T_HOUR] = {twenty_four_hour, 1'b0, twenty_four_hour ? hourN[5:0] : {pm ^ (hourVal == BCD_11), hourN[4:0]}};
                if (dayCarry)
                begin
                    timeD[T_WDAY] = (timeQ[T_WDAY][2:0] == WDAY_MAX) ? 8'h00 : timeQ[T_WDAY] + 8'h01;
                    timeD[T_DATE] = dateN;
                    if (dateW)
                        timeD[T_MON] = monN;
                    if (dateW && monW)
                        timeD[T_YEAR] = yearN;
                end
            end
        end
        if (snapTake)
            snapD = timeQ;
        if (wrStb)
        begin
            if (ptrQ <= A_WDAY)
            begin
                if (wrtcQ)
                begin
                    timeD[ptrQ[2:0]] = shQ & TIME_MASK[ptrQ[2:0]];
                    clkWrD = 1'b1;
                    rtcfD  = 1'b0;
                end
            end
            else if (ptrQ >= A_ALSEC && ptrQ <= A_ALWD)
                alrmD[3'(ptrQ - A_ALSEC)] = shQ & ALRM_MASK[3'(ptrQ - A_ALSEC)];
            else
            begin
                unique case (ptrQ)
                    A_SR:
                    begin
                        arstD  = shQ[SR_AUTO_CLEAR_ENABLE];
                        xtoscD = shQ[SR_XTOSC];
                        wrtcD  = shQ[SR_CLOCK_WRITE_ENABLE];
                        if (!shQ[SR_ALM])
                            almD = 1'b0;
                        if (!shQ[SR_BAT])
                            batD = 1'b0;
                    end
                    A_CFG:   cfgD = shQ;
                    A_ATRIM: atrimD = shQ;
                    A_DTRIM: dtrimD = shQ & DTRIM_MASK;
                    A_USER_BYTE_ONE:  usrD[0] = shQ;
                    A_USER_BYTE_TWO:  usrD[1] = shQ;
                    default: cfgD = cfgQ;
                endcase
            end
        end
        if (rdLoad && ptrQ == A_SR)
        begin
            srRdD   = 1'b1;
            srMaskD = srMaskQ | {almQ, batQ};
        end
        if (startEv || stopEv)
        begin
            if (stopEv && srRdQ && arstQ)
            begin
                // only bits seen by the read are cleared, so a fresh alarm survives
                if (srMaskQ[1])
                    almD = 1'b0;
                if (srMaskQ[0])
                    batD = 1'b0;
            end
            if (stopEv && clkWrQ)
                runD = 1'b1;
            clkWrD  = 1'b0;
            srRdD   = 1'b0;
            srMaskD = 2'b00;
        end
        if (almEvent)
            almD = 1'b1;
        if (batS && !batPrevQ)
            batD = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 7; i++)
            begin
                timeQ[i] <= REG_RESET;
                snapQ[i] <= REG_RESET;
            end
            for (int i = 0; i < 6; i++)
                alrmQ[i] <= REG_RESET;
            usrQ[0]  <= REG_RESET;
            usrQ[1]  <= REG_RESET;
            cfgQ     <= REG_RESET;
            atrimQ   <= REG_RESET;
            dtrimQ   <= REG_RESET;
            arstQ    <= SR_RESET[SR_AUTO_CLEAR_ENABLE];
            xtoscQ   <= SR_RESET[SR_XTOSC];
            wrtcQ    <= SR_RESET[SR_CLOCK_WRITE_ENABLE];
            almQ     <= SR_RESET[SR_ALM];
            batQ     <= SR_RESET[SR_BAT];
            rtcfQ    <= SR_RESET[SR_RTCF];
            runQ     <= 1'b0;
            clkWrQ   <= 1'b0;
            srRdQ    <= 1'b0;
            srMaskQ  <= 2'b00;
            batPrevQ <= 1'b1;
        end
        else
        begin
            timeQ    <= timeD;
            snapQ    <= snapD;
            alrmQ    <= alrmD;
            usrQ     <= usrD;
            cfgQ     <= cfgD;
            atrimQ   <= atrimD;
            dtrimQ   <= dtrimD;
            arstQ    <= arstD;
            xtoscQ   <= xtoscD;
            wrtcQ    <= wrtcD;
            almQ     <= almD;
            batQ     <= batD;
            rtcfQ    <= rtcfD;
            runQ     <= runD;
            clkWrQ   <= clkWrD;
            srRdQ    <= srRdD;
            srMaskQ  <= srMaskD;
            batPrevQ <= batS;
        end
    end

    // timebase, alarm pulse and shared pin
    logic [3:0] fsel;
    logic       wave, alarmLow;

    assign fsel     = cfgQ[3:0];
    assign wave     = (fsel == 4'h1) ? xtalS : prescQ[FREQ_TAP[fsel]];
    assign alarmLow = alarmOn && (cfgQ[CF_IM] ? (pulseQ != '0) : almQ);

    always_comb
    begin
        prescD  = prescQ;
        tickD   = 1'b0;
        pulseD  = pulseQ;
        if (stopEv && clkWrQ)
            prescD = '0;
        else if (xtalS && !xtalPrevQ)
        begin
            prescD = prescQ + 1'b1;
            tickD  = (prescQ[14:0] == PRESC_SEC_WRAP);
        end
        if (almEvent && cfgQ[CF_IM])
            pulseD = PW'(PULSE_CYCLES);
        else if (pulseQ != '0)
            pulseD = pulseQ - 1'b1;
        pinLowD = !(batS && cfgQ[CF_FOBAT]) && ((fsel != 4'h0) ? !wave : alarmLow);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            xtalPrevQ <= 1'b1;
            prescQ    <= '0;
            tickQ     <= 1'b0;
            tickDlyQ  <= 1'b0;
            pulseQ    <= '0;
            pinLowQ   <= 1'b0;
        end
        else
        begin
            xtalPrevQ <= xtalS;
            prescQ    <= prescD;
            tickQ     <= tickD;
            tickDlyQ  <= tickQ && runQ;
            pulseQ    <= pulseD;
            pinLowQ   <= pinLowD;
        end
    end

    assign alarmFreqOut = 1'b0;
    assign alarmFreqOe  = pinLowQ;
endmodule

// >>> tb/rca_rtc_monitor.sv
// Purpose: port checks for the serial slave and the shared pin.
// Assumes: bus clock phases of at least 16 system clocks.
// Notes: open drain data values stay 0; only the enables move.
`timescale 1ns/100ps
module rca_rtc_monitor
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sclPin,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic onBatteryPin,
    input wire logic alarmFreqOut,
    input wire logic alarmFreqOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_sda_value: assert property (sdaOut == 1'b0) else $error("sda data high");
    a_pin_value: assert property (alarmFreqOut == 1'b0) else $error("pin data high");
    a_reset_quiet: assert property ($rose(rstn) |-> !sdaOe && !alarmFreqOe) else $error("drive at reset");
    a_bat_quiet: assert property (onBatteryPin [*8] |-> !sdaOe) else $error("bus on battery");
    // sync lag is about 4 clocks, so 6 samples leave margin
    a_scl_hold: assert property (sclPin [*6] |-> $stable(sdaOe)) else $error("sda moved, scl high");
    a_rise_low: assert property ($rose(sdaOe) |-> !sclPin) else $error("drive began, scl high");
    a_fall_low: assert property ($fell(sdaOe) |-> !sclPin) else $error("release, scl high");
    a_bit_stand: assert property ($rose(sdaOe) |-> sdaOe [*4]) else $error("short low bit");
endmodule
bind rca_rtc_top rca_rtc_monitor rca_rtc_monitor_inst (.*);

// >>> tb/rca_host.sv
// Purpose: serial bus host model, clock and open drain data.
// Assumes: half bit of 16 system clocks.
// Notes: data bits change sda 4 clocks after scl falls; start and stop change it mid scl high, never near an edge.
`timescale 1ns/100ps
module rca_host
(
    input  wire logic clk_sys,
    input  wire logic sdaIn,
    output logic      sclPin,
    output logic      sdaLow
);
    initial
    begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic hp();
        repeat (16) @(negedge clk_sys);
    endtask
    task automatic xbit(input logic b, output logic r);
        repeat (4) @(negedge clk_sys);
        sdaLow = !b;
        hp();
        sclPin = 1'b1;
        hp();
        r = sdaIn;
        sclPin = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(m, a);
    endtask
    task automatic start();
        sdaLow = 1'b0;
        hp();
        sclPin = 1'b1;
        hp();
        sdaLow = 1'b1;
        hp();
        sclPin = 1'b0;
    endtask
    task automatic stop();
        repeat (4) @(negedge clk_sys);
        sdaLow = 1'b1;
        hp();
        sclPin = 1'b1;
        hp();
        sdaLow = 1'b0;
        hp();
    endtask
endmodule

// >>> tb/rca_rtc_tb_top.sv
// Purpose: self-checking bench for registers and the shared pin.
// Assumes: no second ticks; one takes 32768 crystal edges, too long here.
// Notes: the host model makes every bus cycle.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module rca_rtc_tb_top;
    import rca_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic xtalIn = 1'b0;
    logic onBatteryPin = 1'b0;
    logic sclPin, sdaLow, sdaOut, sdaOe, alarmFreqOut, alarmFreqOe, a;
    logic [7:0] q;
    logic [15:0] v;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n1, n2;
    wire sdaIn = !(sdaOe || sdaLow);
    always #4 clk_sys = ~clk_sys;
    initial #3.3 forever #32 xtalIn = ~xtalIn;
    rca_rtc_top #(.PULSE_CYCLES(50)) rca_rtc_top_inst (.*);
    rca_host rca_host_inst (.*);
    task automatic close_out();
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
        rca_host_inst.start();
        rca_host_inst.xbyte(8'hde, 1'b1, q, a);
        rca_host_inst.xbyte(p, 1'b1, q, a);
        for (int i = n - 1; i >= 0; i--)
            rca_host_inst.xbyte(d[8*i+:8], 1'b1, q, a);
        `CHK("write ack", 1'b0, a)
        rca_host_inst.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic ptr, input int n);
        if (ptr)
        begin
            rca_host_inst.start();
            rca_host_inst.xbyte(8'hde, 1'b1, q, a);
            rca_host_inst.xbyte(p, 1'b1, q, a);
        end
        rca_host_inst.start();
        rca_host_inst.xbyte(8'hdf, 1'b1, q, a);
        for (int i = 1; i <= n; i++)
        begin
            rca_host_inst.xbyte(8'hff, i == n, q, a);
            v = {v[7:0], q};
        end
        rca_host_inst.stop();
    endtask
    task automatic cnt(output int n);
        logic p;
        n = 0;
        p = alarmFreqOe;
        repeat (400)
        begin
            @(negedge clk_sys);
            n += int'(alarmFreqOe & !p);
            p = alarmFreqOe;
        end
    endtask
    task automatic t_defaults();
        for (int r = 0; r < 20; r++)
        begin
            rd(8'(r), 1'b1, 1);
            `CHK("reset value", (r == 7) ? SR_RESET : REG_RESET, v[7:0])
        end
        wr(A_UNUSE, 16'h005a, 1);
        rd(A_UNUSE, 1'b1, 1);
        `CHK("unused slot", 8'h00, v[7:0])
    endtask
    task automatic t_clock();
        wr(A_SEC, 16'h0030, 1);
        rd(A_SEC, 1'b1, 1);
        `CHK("locked seconds", 8'h00, v[7:0])
        wr(A_SR, 16'h0010, 1);
        wr(A_WDAY, 16'h0545, 2);
        rd(A_WDAY, 1'b1, 2);
        `CHK("wrapped clock pair", 16'h0545, v)
        rd(A_SR, 1'b1, 1);
        `CHK("status after write", 8'h10, v[7:0])
    endtask
    task automatic t_user();
        wr(A_USER_BYTE_TWO, 16'haa55, 2);
        rd(A_USER_BYTE_ONE, 1'b1, 1);
        `CHK("user one", 8'h55, v[7:0])
        rd(A_SEC, 1'b0, 1);
        `CHK("current address", 8'haa, v[7:0])
        rca_host_inst.start();
        rca_host_inst.xbyte(8'hd0, 1'b1, q, a);
        rca_host_inst.stop();
        `CHK("foreign address", 1'b1, a)
    endtask
    task automatic t_pin();
        wr(A_CFG, 16'h0001, 1);
        cnt(n1);
        wr(A_CFG, 16'h0012, 1);
        cnt(n2);
        `CHK("rate order", 1'b1, n1 > 4 * n2 && n2 > 0)
        onBatteryPin = 1'b1;
        repeat (8) @(negedge clk_sys);
        cnt(n2);
        `CHK("silent on backup", 0, n2)
        `CHK("pin released", 1'b0, alarmFreqOe)
        onBatteryPin = 1'b0;
        rd(A_USER_BYTE_ONE, 1'b1, 1);
        `CHK("user kept", 8'h55, v[7:0])
        // writing 1 to the flag bits leaves them alone
        wr(A_SR, 16'h0092, 1);
        rd(A_SR, 1'b1, 1);
        `CHK("battery flag", 8'h92, v[7:0])
        rd(A_SR, 1'b1, 1);
        `CHK("auto cleared", 8'h90, v[7:0])
    endtask
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (8) @(negedge clk_sys);
        t_defaults();
        t_clock();
        t_user();
        t_pin();
        close_out();
    end
endmodule
